// ===== aotp_formatter.sv
// Purpose: Output word formatting and test pattern generation with a serial lane on the link clock.
// Assumes: Converter samples arrive offset binary on clk_sys_in; clk_link_in runs free.
// Notes:   Words cross to the link domain by a toggle handshake; one word per handshake.
`timescale 1ns/1ns
`default_nettype none
module aotp_formatter
  import aotp_pkg::*;
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   clk_link_in,
  input  wire logic [SAMPLE_BITS-1:0] adc_sample_in,
  input  wire aotp_pkg::aotp_reg_wr_t reg_wr_in,
  input  wire logic [7:0]             reg_rd_addr_in,
  input  wire logic                   cfg_lsb_first_in,
  input  wire logic                   cfg_twos_comp_in,
  input  wire logic [4:0]             cfg_word_len_in,
  input  wire logic                   cfg_power_down_in,
  input  wire logic                   port_select_n_in,
  input  wire logic                   serial_clock_format_pin_in,
  input  wire logic                   serial_io_powerdown_pin_in,
  output logic [7:0]                  reg_rd_data_out,
  output logic                        device_power_down_out,
  output aotp_pkg::aotp_lane_t        lane_out
);
  import aotp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks on the package constants the logic is built around.

  // The sample and its two stuffing bits must fill the 16-bit word exactly.
  if (SAMPLE_BITS + 2 != 16) begin : g_chk_sample
    $error("sample width does not fill a 16-bit word");
  end
  // The serializer holds 16 bits, so the length range must end there.
  if ((WORD_LEN_MAX != 5'h10) || (WORD_LEN_MIN > WORD_LEN_MAX)) begin : g_chk_len
    $error("word length range does not fit the serializer");
  end
  // Feedback taps must name stages below the output stage.
  if ((SHORT_PRBS_TAP > 7) || (LONG_PRBS_TAP > 21)) begin : g_chk_tap
    $error("PRBS tap outside its generator");
  end
  // The start-up counter stops at three, so a capture point there would repeat.
  if (STRAP_CAPTURE_CNT == 2'h3) begin : g_chk_strap
    $error("strap capture point is never left");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  function automatic logic [15:0] bit_reverse(input logic [15:0] w);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = w[15-i];
    end
    return r;
  endfunction

  // Short generator: fourteen steps of x^9 + x^5 + 1, oldest stage out first.
  function automatic logic [22:0] short_step(input logic [8:0] s);
    logic [8:0]  st;
    logic [13:0] bits;
    st   = s;
    bits = '0;
    for (int i = 13; i >= 0; i--) begin
      bits[i] = st[8];
      st      = {st[7:0], st[8] ^ st[SHORT_PRBS_TAP]};
    end
    return {bits, st};
  endfunction

  // Long generator: fourteen steps of x^23 + x^18 + 1.
  // The stream leaves uninverted from the all-ones seed, which gives the expected first words.
  function automatic logic [36:0] long_step(input logic [22:0] s);
    logic [22:0] st;
    logic [13:0] bits;
    st   = s;
    bits = '0;
    for (int i = 13; i >= 0; i--) begin
      bits[i] = st[22];
      st      = {st[21:0], st[22] ^ st[LONG_PRBS_TAP]};
    end
    return {bits, st};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock domain: registers, straps, pattern selection and word build.

  aotp_sys_state_t sys_q;
  aotp_sys_state_t sys_d;

  logic        strap_mode;
  logic        twos_sel;
  logic [4:0]  word_len;
  logic [4:0]  low_bits;
  logic [15:0] len_mask;
  logic [15:0] base_word;
  logic        fmt_apply;
  logic        alt_pattern;
  logic [15:0] fmt_word;
  logic [15:0] cut_word;
  logic [22:0] short_nx;
  logic [36:0] long_nx;
  logic        produce;
  aotp_mode_t  mode;
  // Request toggle of the link side, read in this domain only through two stages.
  logic        lane_req_tog;

  always_comb begin
    sys_d = sys_q;
    sys_d.req_s1  = lane_req_tog;
    sys_d.req_s2  = sys_q.req_s1;
    sys_d.csn_s1  = port_select_n_in;
    sys_d.csn_s2  = sys_q.csn_s1;
    sys_d.sclk_s1 = serial_clock_format_pin_in;
    sys_d.sclk_s2 = sys_q.sclk_s1;
    sys_d.sdio_s1 = serial_io_powerdown_pin_in;
    sys_d.sdio_s2 = sys_q.sdio_s1;

    strap_mode = sys_q.csn_s2;
    if (sys_q.init_cnt != 2'h3) begin
      sys_d.init_cnt = sys_q.init_cnt + 2'h1;
    end
    // The format strap is captured once, after the pin has crossed both stages,
    // and is then left alone until the next reset.
    if (sys_q.init_cnt == STRAP_CAPTURE_CNT) begin
      sys_d.fmt_strap = sys_q.sclk_s2;
    end
    twos_sel = strap_mode ? sys_q.fmt_strap : cfg_twos_comp_in;

    // A write to the test mode register restarts the alternation, so the first word of a pair
    // leads after a mode change, unless a pair word is built in the write cycle, whose toggle wins.
    if (reg_wr_in.wr && !strap_mode) begin
      if (reg_wr_in.addr == REG_TEST_MODE) begin
        sys_d.test_mode = reg_wr_in.data;
        sys_d.alt       = 1'b0;
      end else if (reg_wr_in.addr == REG_USER1_LO) begin
        sys_d.user1_lo = reg_wr_in.data;
      end else if (reg_wr_in.addr == REG_USER1_HI) begin
        sys_d.user1_hi = reg_wr_in.data;
      end else if (reg_wr_in.addr == REG_USER2_LO) begin
        sys_d.user2_lo = reg_wr_in.data;
      end else if (reg_wr_in.addr == REG_USER2_HI) begin
        sys_d.user2_hi = reg_wr_in.data;
      end
    end

    // Read data is registered, so it follows the address one clock later.
    if (reg_rd_addr_in == REG_TEST_MODE) begin
      sys_d.rdata = sys_q.test_mode;
    end else if (reg_rd_addr_in == REG_USER1_LO) begin
      sys_d.rdata = sys_q.user1_lo;
    end else if (reg_rd_addr_in == REG_USER1_HI) begin
      sys_d.rdata = sys_q.user1_hi;
    end else if (reg_rd_addr_in == REG_USER2_LO) begin
      sys_d.rdata = sys_q.user2_lo;
    end else if (reg_rd_addr_in == REG_USER2_HI) begin
      sys_d.rdata = sys_q.user2_hi;
    end else begin
      sys_d.rdata = 8'h00;
    end

    // Out-of-range lengths fall back to the full 16-bit word.
    if ((cfg_word_len_in < WORD_LEN_MIN) || (cfg_word_len_in > WORD_LEN_MAX)) begin
      word_len = WORD_LEN_MAX;
    end else begin
      word_len = cfg_word_len_in;
    end
    low_bits = WORD_LEN_MAX - word_len;
    len_mask = 16'hffff << low_bits;

    short_nx = short_step(sys_q.short_lfsr);
    long_nx  = long_step(sys_q.long_lfsr);

    mode        = aotp_mode_t'(sys_q.test_mode[3:0]);
    fmt_apply   = 1'b1;
    alt_pattern = 1'b0;
    case (mode)
      TM_OFF: begin
        base_word = {adc_sample_in, 2'b00};
      end
      TM_MIDSCALE: begin
        base_word = PAT_MIDSCALE;
      end
      TM_POS_FS: begin
        base_word = PAT_POS_FS;
      end
      TM_NEG_FS: begin
        base_word = PAT_NEG_FS;
      end
      TM_CHECKER: begin
        base_word   = sys_q.alt ? PAT_CHECK_B : PAT_CHECK_A;
        fmt_apply   = 1'b0;
        alt_pattern = 1'b1;
      end
      TM_LONG_PRBS: begin
        base_word = {long_nx[36:23], 2'b00};
      end
      TM_SHORT_PRBS: begin
        base_word = {short_nx[22:9], 2'b00};
      end
      TM_WORD_TOGGLE: begin
        base_word   = sys_q.alt ? PAT_ZEROS : PAT_ONES;
        fmt_apply   = 1'b0;
        alt_pattern = 1'b1;
      end
      TM_USER: begin
        base_word   = sys_q.alt ? {sys_q.user2_hi, sys_q.user2_lo}
                                : {sys_q.user1_hi, sys_q.user1_lo};
        fmt_apply   = 1'b0;
        alt_pattern = 1'b1;
      end
      TM_BIT_TOGGLE: begin
        base_word = PAT_CHECK_A;
        fmt_apply = 1'b0;
      end
      TM_SYNC: begin
        base_word = (word_len == WORD_LEN_MIN) ? PAT_SYNC12 : PAT_SYNC16;
        fmt_apply = 1'b0;
      end
      TM_ONE_HIGH: begin
        base_word = PAT_ONE_HIGH;
        fmt_apply = 1'b0;
      end
      TM_MIXED: begin
        base_word = (word_len == WORD_LEN_MIN) ? PAT_MIX12 : PAT_MIX16;
        fmt_apply = 1'b0;
      end
      default: begin
        base_word = PAT_ZEROS;
        fmt_apply = 1'b0;
      end
    endcase

    // Offset binary to twos complement is a flip of the sample MSB.
    fmt_word = (fmt_apply && twos_sel) ? {~base_word[15], base_word[14:0]} : base_word;
    // Bits below the chosen length are cleared so shorter words stay left aligned.
    cut_word = fmt_word & len_mask;

    // A new word is built once the link side has taken the previous one.
    produce = (sys_q.req_s2 == sys_q.ack_tog);
    if (produce) begin
      // Word fields are frozen here, so a mode or length change waits for a boundary.
      sys_d.xfer.len  = word_len;
      if (cfg_lsb_first_in) begin
        sys_d.xfer.bits = bit_reverse(cut_word) << low_bits;
      end else begin
        sys_d.xfer.bits = cut_word;
      end
      sys_d.ack_tog = ~sys_q.ack_tog;
      if (alt_pattern) begin
        sys_d.alt = ~sys_q.alt;
      end
      if (mode == TM_SHORT_PRBS) begin
        sys_d.short_lfsr = short_nx[8:0];
      end
      if (mode == TM_LONG_PRBS) begin
        sys_d.long_lfsr = long_nx[22:0];
      end
    end
    // A set reset bit overrides the advance, so the generator stays at its seed
    // for as long as the bit is held.
    if (sys_q.test_mode[SHORT_PRBS_RST_BIT]) begin
      sys_d.short_lfsr = SHORT_PRBS_SEED;
    end
    if (sys_q.test_mode[LONG_PRBS_RST_BIT]) begin
      sys_d.long_lfsr = LONG_PRBS_SEED;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sys_q            <= '0;
      sys_q.test_mode  <= TEST_MODE_RESET;
      sys_q.user1_lo   <= USER_RESET;
      sys_q.user1_hi   <= USER_RESET;
      sys_q.user2_lo   <= USER_RESET;
      sys_q.user2_hi   <= USER_RESET;
      sys_q.short_lfsr <= SHORT_PRBS_SEED;
      sys_q.long_lfsr  <= LONG_PRBS_SEED;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign reg_rd_data_out       = sys_q.rdata;
  // Power-down from the config input acts at once in this domain, from the pin after two stages;
  // the lane side sees it through two more stages, so the drivers turn off a few link cycles later.
  assign device_power_down_out = sys_q.csn_s2 ? sys_q.sdio_s2 : cfg_power_down_in;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: serializer fed by the handshake.

  aotp_link_state_t link_q;
  aotp_link_state_t link_d;
  logic             word_avail;
  // The word register stays still from an ack toggle until the link answers it,
  // so the link reads it only once that toggle has passed two stages.

  assign lane_req_tog = link_q.req_tog;

  always_comb begin
    link_d = link_q;
    link_d.rst_s1 = sys_rst_in;
    link_d.rst_s2 = link_q.rst_s1;
    link_d.ack_s1 = sys_q.ack_tog;
    link_d.ack_s2 = link_q.ack_s1;
    link_d.pd_s1  = device_power_down_out;
    link_d.pd_s2  = link_q.pd_s1;

    word_avail         = (link_q.ack_s2 != link_q.req_tog);
    link_d.lane.frame  = 1'b0;
    link_d.lane.oe     = ~link_q.pd_s2;
    if (link_q.cnt != 5'h00) begin
      link_d.lane.data = link_q.shift[15];
      link_d.shift     = {link_q.shift[14:0], 1'b0};
      link_d.cnt       = link_q.cnt - 5'h01;
    end else if (word_avail) begin
      // The word and its length are loaded together at the boundary.
      link_d.lane.data  = sys_q.xfer.bits[15];
      link_d.lane.frame = 1'b1;
      link_d.shift      = {sys_q.xfer.bits[14:0], 1'b0};
      link_d.cnt        = sys_q.xfer.len - 5'h01;
      link_d.req_tog    = link_q.ack_s2;
    end else begin
      link_d.lane.data = 1'b0;
    end
    if (link_q.pd_s2) begin
      link_d.lane.data  = 1'b0;
      link_d.lane.frame = 1'b0;
    end
  end

  // The reset branch keeps the reset stages running so that the release is seen.
  always_ff @(posedge clk_link_in) begin
    if (link_q.rst_s2) begin
      link_q        <= '0;
      link_q.rst_s1 <= link_d.rst_s1;
      link_q.rst_s2 <= link_d.rst_s2;
    end else begin
      link_q <= link_d;
    end
  end

  assign lane_out = link_q.lane;

endmodule // aotp_formatter
`default_nettype wire

// ===== aotp_formatter_sva.sv
// Purpose: Port-level checks of the output test pattern formatter.
// Assumes: Link clock runs free; reset is synchronous and active high.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/1ns
`default_nettype none
module aotp_formatter_sva
  import aotp_pkg::*;
(
  input wire logic                 clk_sys_in,
  input wire logic                 sys_rst_in,
  input wire logic                 clk_link_in,
  input wire logic [7:0]           reg_rd_addr_in,
  input wire logic                 cfg_power_down_in,
  input wire logic                 port_select_n_in,
  input wire logic                 serial_io_powerdown_pin_in,
  input wire logic [7:0]           reg_rd_data_out,
  input wire logic                 device_power_down_out,
  input wire aotp_pkg::aotp_lane_t lane_out
);
  import aotp_pkg::*;
  // A word is never shorter than twelve bits.
  sequence s_word_gap;
    (!lane_out.frame)[*8] ##1 (!lane_out.frame)[*3];
  endsequence
  sequence s_pd_held;
    device_power_down_out[*4];
  endsequence

  a_word_gap_min: assert property (@(posedge clk_link_in) disable iff (sys_rst_in)
    lane_out.frame |=> s_word_gap) else $error("frame gap below twelve bits");
  a_pd_lane_quiet: assert property (@(posedge clk_link_in) disable iff (sys_rst_in)
    s_pd_held |-> lane_out == 3'b000) else $error("lane active while powered down");
  a_run_lane_live: assert property (@(posedge clk_link_in) disable iff (sys_rst_in)
    (!device_power_down_out)[*6] |-> lane_out.oe) else $error("lane off while running");
  a_strap_pd_high: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (port_select_n_in && serial_io_powerdown_pin_in)[*4] |-> device_power_down_out)
    else $error("strap high did not power down");
  a_strap_pd_low: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (port_select_n_in && !serial_io_powerdown_pin_in)[*4] |-> !device_power_down_out)
    else $error("strap low powered down");
  a_cfg_pd_high: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!port_select_n_in && cfg_power_down_in)[*4] |-> device_power_down_out)
    else $error("config request did not power down");
  a_cfg_pd_low: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!port_select_n_in && !cfg_power_down_in)[*4] |-> !device_power_down_out)
    else $error("powered down without request");
  a_rd_unmapped_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !(reg_rd_addr_in inside {8'h0d, 8'h19, 8'h1a, 8'h1b, 8'h1c}) |=> reg_rd_data_out == 8'h00)
    else $error("unmapped read not zero");
endmodule // aotp_formatter_sva
`default_nettype wire

// ===== aotp_formatter_tb.sv
// Purpose: Self-checking bench of the output test pattern formatter.
// Assumes: Receiver model reassembles words by the configured order and length.
// Notes:   Reset is held long enough for the link domain to see it.
`timescale 1ns/1ns
`default_nettype none
module aotp_formatter_tb;
  import aotp_pkg::*;
  logic         clk_sys_in, sys_rst_in, clk_link_in, cfg_lsb_first_in, cfg_twos_comp_in;
  logic         cfg_power_down_in, port_select_n_in, fmt_pin, pd_pin, device_power_down_out;
  logic [13:0]  adc_sample_in;
  logic [4:0]   cfg_word_len_in;
  logic [7:0]   reg_rd_addr_in, reg_rd_data_out;
  logic [15:0]  rx_word, word_cnt;
  aotp_reg_wr_t reg_wr_in;
  aotp_lane_t   lane_out;
  int           fails, check_count, cyc;

  aotp_formatter dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .clk_link_in(clk_link_in), .adc_sample_in(adc_sample_in), .reg_wr_in(reg_wr_in),
    .reg_rd_addr_in(reg_rd_addr_in), .cfg_lsb_first_in(cfg_lsb_first_in),
    .cfg_twos_comp_in(cfg_twos_comp_in), .cfg_word_len_in(cfg_word_len_in),
    .cfg_power_down_in(cfg_power_down_in), .port_select_n_in(port_select_n_in),
    .serial_clock_format_pin_in(fmt_pin), .serial_io_powerdown_pin_in(pd_pin),
    .reg_rd_data_out(reg_rd_data_out), .device_power_down_out(device_power_down_out),
    .lane_out(lane_out));
  aotp_lvds_rx rx_u (.clk_link_in(clk_link_in), .lane_in(lane_out),
    .lsb_first_in(cfg_lsb_first_in), .word_len_in(cfg_word_len_in),
    .word_out(rx_word), .word_cnt_out(word_cnt));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // The link clock has an odd half period at 1 ns resolution, so its halves alternate.
  initial begin
    clk_link_in = 1'b0;
    #7;
    forever begin
      #62 clk_link_in = 1'b1;
      #63 clk_link_in = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic cmp_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_wr_in = '{wr: 1'b1, addr: a, data: d};
    tick(1);
    reg_wr_in.wr = 1'b0;
    tick(1);
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    reg_rd_addr_in = a;
    tick(1);
    cmp_reg("register", exp, reg_rd_data_out);
  endtask
  task automatic get_word(output logic [15:0] w);
    logic [15:0] c;
    c = word_cnt;
    for (int i = 0; i < 400 && word_cnt === c; i++) tick(1);
    w = rx_word;
  endtask
  // Sets a mode and checks two consecutive words against an alternating pair.
  task automatic check_mode(input logic [3:0] m, input logic [4:0] len, input logic tc,
                            input logic lsb, input logic [15:0] a, input logic [15:0] b);
    logic [15:0] w1, w2;
    cfg_word_len_in = len;
    cfg_twos_comp_in = tc;
    cfg_lsb_first_in = lsb;
    reg_write(8'h0d, {4'h0, m});
    repeat (4) get_word(w1);
    get_word(w2);
    cmp_word("word one", (w1 === a) ? a : b, w1);
    cmp_word("word two", (w1 === a) ? b : a, w2);
  endtask
  task automatic check_prbs(input logic [7:0] hold, input logic [15:0] e0, input logic [15:0] e1,
                            input logic [15:0] e2, input logic [15:0] e3);
    logic [15:0] w;
    reg_write(8'h0d, hold);
    reg_read(8'h0d, hold);
    repeat (4) get_word(w);
    cmp_word("prbs seed", e0, w);
    reg_write(8'h0d, {4'h0, hold[3:0]});
    for (int i = 0; i < 8 && w === e0; i++) get_word(w);
    cmp_word("prbs next", e1, w);
    get_word(w);
    cmp_word("prbs next", e2, w);
    get_word(w);
    cmp_word("prbs next", e3, w);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cfg_lsb_first_in, cfg_twos_comp_in, cfg_power_down_in, port_select_n_in} = 4'h0;
    {fmt_pin, pd_pin, fails, check_count, cyc} = '0;
    adc_sample_in = 14'h2abc;
    cfg_word_len_in = 5'h10;
    reg_rd_addr_in = 8'h00;
    reg_wr_in = '0;
    sys_rst_in = 1'b1;
    tick(40);
    sys_rst_in = 1'b0;
    for (int i = 0; i < 5; i++) reg_read(8'h0d + ((i == 0) ? 8'h00 : 8'h0b + i[7:0]), 8'h00);
    reg_write(8'h20, 8'hff);
    reg_read(8'h20, 8'h00);
    reg_write(8'h19, 8'ha5);
    reg_write(8'h1a, 8'hc3);
    reg_write(8'h1b, 8'h3c);
    reg_write(8'h1c, 8'h5a);
    reg_read(8'h1c, 8'h5a);
    check_mode(4'h0, 5'h10, 1'b0, 1'b0, 16'haaf0, 16'haaf0);
    check_mode(4'h0, 5'h10, 1'b1, 1'b0, 16'h2af0, 16'h2af0);
    check_mode(4'h1, 5'h10, 1'b1, 1'b0, 16'h0000, 16'h0000);
    check_mode(4'h1, 5'h0e, 1'b0, 1'b0, 16'h8000, 16'h8000);
    check_mode(4'h2, 5'h10, 1'b1, 1'b0, 16'h7ffc, 16'h7ffc);
    check_mode(4'h3, 5'h0d, 1'b1, 1'b0, 16'h8000, 16'h8000);
    check_mode(4'h4, 5'h10, 1'b1, 1'b0, 16'haaa8, 16'h5554);
    check_mode(4'h7, 5'h10, 1'b1, 1'b0, 16'hfffc, 16'h0000);
    check_mode(4'h8, 5'h10, 1'b1, 1'b0, 16'hc3a5, 16'h5a3c);
    check_mode(4'h9, 5'h0c, 1'b1, 1'b0, 16'haaa0, 16'haaa0);
    check_mode(4'ha, 5'h10, 1'b1, 1'b1, 16'h01fc, 16'h01fc);
    check_mode(4'ha, 5'h0c, 1'b0, 1'b0, 16'h03f0, 16'h03f0);
    check_mode(4'hb, 5'h0f, 1'b1, 1'b0, 16'h8000, 16'h8000);
    check_mode(4'hc, 5'h10, 1'b0, 1'b0, 16'ha19c, 16'ha19c);
    check_mode(4'hc, 5'h0c, 1'b1, 1'b0, 16'ha330, 16'ha330);
    cfg_word_len_in = 5'h10;
    check_prbs(8'h16, 16'h7f80, 16'h77c4, 16'hf320, 16'ha538);
    check_prbs(8'h25, 16'h7ffc, 16'h7f80, 16'h8004, 16'h7000);
    port_select_n_in = 1'b1;
    tick(4);
    reg_write(8'h0d, 8'h01);
    reg_read(8'h0d, 8'h05);
    pd_pin = 1'b1;
    tick(60);
    cmp_reg("power down", 8'h01, {7'h00, device_power_down_out});
    cmp_reg("lane", 8'h00, {5'h00, lane_out});
    pd_pin = 1'b0;
    port_select_n_in = 1'b0;
    cfg_power_down_in = 1'b1;
    tick(4);
    cmp_reg("power down", 8'h01, {7'h00, device_power_down_out});
    cfg_power_down_in = 1'b0;
    port_select_n_in = 1'b1;
    fmt_pin = 1'b1;
    sys_rst_in = 1'b1;
    tick(40);
    sys_rst_in = 1'b0;
    check_mode(4'h0, 5'h10, 1'b0, 1'b0, 16'h2af0, 16'h2af0);
    complete_run();
  end
endmodule // aotp_formatter_tb

bind aotp_formatter aotp_formatter_sva chk_u (.clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in), .clk_link_in(clk_link_in), .reg_rd_addr_in(reg_rd_addr_in),
  .cfg_power_down_in(cfg_power_down_in), .port_select_n_in(port_select_n_in),
  .serial_io_powerdown_pin_in(serial_io_powerdown_pin_in),
  .reg_rd_data_out(reg_rd_data_out), .device_power_down_out(device_power_down_out),
  .lane_out(lane_out));
`default_nettype wire

// ===== aotp_lvds_rx.sv
// Purpose: Receiver model that captures serial words from the lane.
// Assumes: Frame marks the first bit of each word; length is 12 to 16 bits.
// Notes:   Words are presented left aligned in 16 bits with a running count.
`timescale 1ns/1ns
`default_nettype none
module aotp_lvds_rx
  import aotp_pkg::*;
(
  input  wire logic                 clk_link_in,
  input  wire aotp_pkg::aotp_lane_t lane_in,
  input  wire logic                 lsb_first_in,
  input  wire logic [4:0]           word_len_in,
  output logic [15:0]               word_out,
  output logic [15:0]               word_cnt_out
);
  import aotp_pkg::*;
  logic [15:0] shift_q;
  logic [4:0]  got_q;
  logic [4:0]  len_q;
  initial begin
    word_out = 16'h0000;
    word_cnt_out = 16'h0000;
    shift_q = 16'h0000;
    got_q = 5'h00;
    len_q = 5'h10;
  end
  always @(posedge clk_link_in) begin
    if (lane_in.oe && lane_in.frame) begin
      len_q = (word_len_in < 5'h0c || word_len_in > 5'h10) ? 5'h10 : word_len_in;
      got_q = 5'h00;
    end
    if (lane_in.oe && (lane_in.frame || got_q != 5'h00)) begin
      shift_q = lsb_first_in ? {lane_in.data, shift_q[15:1]} : {shift_q[14:0], lane_in.data};
      got_q = got_q + 5'h01;
      if (got_q == len_q) begin
        word_out = lsb_first_in ? shift_q & (16'hffff << (5'h10 - len_q))
                                : shift_q << (5'h10 - len_q);
        word_cnt_out = word_cnt_out + 16'h0001;
        got_q = 5'h00;
      end
    end
  end
endmodule // aotp_lvds_rx
`default_nettype wire

// ===== aotp_pkg.sv
// Purpose: Shared constants, pattern words and carrier types of the output test pattern formatter.
// Assumes: Words are 16 bits, MSB aligned, with a 14-bit converter sample in the top bits.
// Notes:   Pattern words are held in their 16-bit form; 12-bit forms sit left aligned.
`default_nettype none
package aotp_pkg;

  localparam logic [7:0] REG_TEST_MODE      = 8'h0d;
  localparam logic [7:0] REG_USER1_LO       = 8'h19;
  localparam logic [7:0] REG_USER1_HI       = 8'h1a;
  localparam logic [7:0] REG_USER2_LO       = 8'h1b;
  localparam logic [7:0] REG_USER2_HI       = 8'h1c;
  localparam logic [7:0] TEST_MODE_RESET    = 8'h00;
  localparam logic [7:0] USER_RESET         = 8'h00;
  localparam int         SHORT_PRBS_RST_BIT = 4;
  localparam int         LONG_PRBS_RST_BIT  = 5;
  localparam int         SAMPLE_BITS        = 14;
  localparam logic [4:0] WORD_LEN_MIN       = 5'h0c;
  localparam logic [4:0] WORD_LEN_MAX       = 5'h10;
  localparam logic [1:0] STRAP_CAPTURE_CNT  = 2'h2;

  typedef enum logic [3:0] {
    TM_OFF         = 4'b0000,
    TM_MIDSCALE    = 4'b0001,
    TM_POS_FS      = 4'b0010,
    TM_NEG_FS      = 4'b0011,
    TM_CHECKER     = 4'b0100,
    TM_LONG_PRBS   = 4'b0101,
    TM_SHORT_PRBS  = 4'b0110,
    TM_WORD_TOGGLE = 4'b0111,
    TM_USER        = 4'b1000,
    TM_BIT_TOGGLE  = 4'b1001,
    TM_SYNC        = 4'b1010,
    TM_ONE_HIGH    = 4'b1011,
    TM_MIXED       = 4'b1100
  } aotp_mode_t;

  localparam logic [15:0] PAT_MIDSCALE = 16'h8000;
  localparam logic [15:0] PAT_POS_FS   = 16'hfffc;
  localparam logic [15:0] PAT_NEG_FS   = 16'h0000;
  localparam logic [15:0] PAT_CHECK_A  = 16'haaa8;
  localparam logic [15:0] PAT_CHECK_B  = 16'h5554;
  localparam logic [15:0] PAT_ONES     = 16'hfffc;
  localparam logic [15:0] PAT_ZEROS    = 16'h0000;
  localparam logic [15:0] PAT_SYNC16   = 16'h01fc;
  localparam logic [15:0] PAT_SYNC12   = 16'h03f0;
  localparam logic [15:0] PAT_ONE_HIGH = 16'h8000;
  localparam logic [15:0] PAT_MIX16    = 16'ha19c;
  localparam logic [15:0] PAT_MIX12    = 16'ha330;

  localparam logic [8:0]  SHORT_PRBS_SEED = 9'h1ff;
  localparam logic [22:0] LONG_PRBS_SEED  = 23'h7fffff;
  localparam int          SHORT_PRBS_TAP  = 4;
  localparam int          LONG_PRBS_TAP   = 17;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } aotp_reg_wr_t;

  typedef struct packed {
    logic [15:0] bits;
    logic [4:0]  len;
  } aotp_word_t;

  typedef struct packed {
    logic data;
    logic frame;
    logic oe;
  } aotp_lane_t;

  typedef struct packed {
    logic [7:0]  test_mode;
    logic [7:0]  user1_lo;
    logic [7:0]  user1_hi;
    logic [7:0]  user2_lo;
    logic [7:0]  user2_hi;
    logic        alt;
    logic [8:0]  short_lfsr;
    logic [22:0] long_lfsr;
    aotp_word_t  xfer;
    logic        ack_tog;
    logic        req_s1;
    logic        req_s2;
    logic        csn_s1;
    logic        csn_s2;
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sdio_s1;
    logic        sdio_s2;
    logic [1:0]  init_cnt;
    logic        fmt_strap;
    logic [7:0]  rdata;
  } aotp_sys_state_t;

  typedef struct packed {
    logic       rst_s1;
    logic       rst_s2;
    logic       ack_s1;
    logic       ack_s2;
    logic       pd_s1;
    logic       pd_s2;
    logic       req_tog;
    logic [15:0] shift;
    logic [4:0] cnt;
    aotp_lane_t lane;
  } aotp_link_state_t;

endpackage
`default_nettype wire
